// ---- hw/cmd_decoder_map.svh ----
// constants of the serial command front end: addresses, opcodes, crc
// assumes inclusion by bare name from every file that decodes commands
`ifndef CMD_DECODER_MAP_SVH
`define CMD_DECODER_MAP_SVH

// fixed 7-bit slave addresses
`define SLAVE_ADDR_STD   7'h74
`define SLAVE_ADDR_ALT   7'h22

// full 7-bit opcodes, command bits 7:1
`define OP_READ_ID       7'h04
`define OP_RESET         7'h08
`define OP_REFRESH       7'h09
`define OP_WR_OPMODE     7'h0a
`define OP_RD_OPMODE     7'h0b
`define OP_AUTO_START    7'h0c
`define OP_AUTO_STOP     7'h0d
`define OP_CONVERT       7'h27
`define OP_WR_NVM        7'h43
`define OP_ERASE_NVM     7'h4b
`define OP_RD_NVM        7'h53
`define OP_WR_REG        7'h70
`define OP_RD_REG        7'h71

// 5-bit prefixes, command bits 7:3, select in bits 2:1
`define OP_WR_CFG        5'h04
`define OP_RD_CFG        5'h05
`define OP_WR_MASK       5'h0c
`define OP_RD_MASK       5'h0d
`define OP_WR_INT        5'h0e
`define OP_RD_INT        5'h0f

// 4-bit prefixes, command bits 7:4, select in bits 3:1
`define OP_WR_LIM        4'hc
`define OP_RD_LIM        4'hd
`define OP_RD_ADC        4'h5

// crc-8 parameters
`define CRC_POLY         8'h31
`define CRC_INIT         8'h00

// user register window: address bits 7:5 of page 4
`define USER_PAGE_BITS   3'h3

// read lengths in bytes
`define LEN_READ_ID      4'h8
`define LEN_WORD         4'h2

`endif

// ---- hw/cmd_pkg.sv ----
// types shared by the command front end
// assumes nothing beyond a SystemVerilog compiler
`default_nettype none
package cmd_pkg;

  typedef enum logic [4:0] {
    CK_NONE       = 5'h00,
    CK_READ_ID    = 5'h01,
    CK_RESET      = 5'h02,
    CK_REFRESH    = 5'h03,
    CK_WR_OPMODE  = 5'h04,
    CK_RD_OPMODE  = 5'h05,
    CK_AUTO_START = 5'h06,
    CK_AUTO_STOP  = 5'h07,
    CK_WR_CFG     = 5'h08,
    CK_RD_CFG     = 5'h09,
    CK_CONVERT    = 5'h0a,
    CK_RD_ADC     = 5'h0b,
    CK_WR_MASK    = 5'h0c,
    CK_RD_MASK    = 5'h0d,
    CK_WR_INT     = 5'h0e,
    CK_RD_INT     = 5'h0f,
    CK_WR_NVM     = 5'h10,
    CK_ERASE_NVM  = 5'h11,
    CK_RD_NVM     = 5'h12,
    CK_WR_LIM     = 5'h13,
    CK_RD_LIM     = 5'h14,
    CK_WR_REG     = 5'h15,
    CK_RD_REG     = 5'h16
  } cmd_kind_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_RX    = 3'b001,
    ST_ACK   = 3'b010,
    ST_TX    = 3'b011,
    ST_TXACK = 3'b100,
    ST_SKIP  = 3'b101
  } link_state_t;

  typedef enum logic [2:0] {
    PH_ADDR  = 3'b000,
    PH_CMD   = 3'b001,
    PH_CCRC  = 3'b010,
    PH_RADDR = 3'b011,
    PH_DATA  = 3'b100,
    PH_DCRC  = 3'b101,
    PH_DONE  = 3'b110
  } phase_t;

  typedef struct packed {
    cmd_kind_t   kind;
    logic [2:0]  sel;
    logic [7:0]  addr;
    logic [15:0] data;
  } cmd_t;

  typedef struct packed {
    logic convRunning;
    logic autoMode;
    logic nvmBusy;
    logic resetBusy;
    logic refreshBusy;
    logic ponBusy;
  } busy_t;

  typedef struct packed {
    logic [23:0] pres;
    logic [23:0] temp1;
    logic [23:0] temp2;
  } adc_t;

endpackage
`default_nettype wire

// ---- hw/crc8_step.sv ----
// one byte step of the crc-8 used on the serial link
// assumes the caller holds the running value in a register
`timescale 1ns/1ps
`default_nettype none
`include "cmd_decoder_map.svh"
module crc8_step (
  input  wire logic [7:0] crcIn,
  input  wire logic [7:0] dataIn,
  output logic      [7:0] crcOut
);
  // msb first, no reflection, no final xor
  always_comb begin
    crcOut = crcIn ^ dataIn;
    for (int i = 0; i < 8; i++) begin
      if (crcOut[7]) begin
        crcOut = {crcOut[6:0], 1'b0} ^ `CRC_POLY;
      end else begin
        crcOut = {crcOut[6:0], 1'b0};
      end
    end
  end
endmodule
`default_nettype wire

// ---- hw/i2c_bus_watch.sv ----
// edge and start/stop detection on the serial bus lines
// assumes scl and sda already synchronous to clk
`timescale 1ns/1ps
`default_nettype none
module i2c_bus_watch (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic sclIn,
  input  wire logic sdaIn,
  output logic      sclRise,
  output logic      sclFall,
  output logic      startSeen,
  output logic      stopSeen
);
  logic sclPrev_r;
  logic sdaPrev_r;

  // previous line levels, idle bus is high
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sclPrev_r <= 1'b1;
      sdaPrev_r <= 1'b1;
    end else begin
      sclPrev_r <= sclIn;
      sdaPrev_r <= sdaIn;
    end
  end

  // sda moving while scl high marks start or stop
  assign sclRise   = sclIn & ~sclPrev_r;
  assign sclFall   = ~sclIn & sclPrev_r;
  assign startSeen = sclIn & sclPrev_r & sdaPrev_r & ~sdaIn;
  assign stopSeen  = sclIn & sclPrev_r & ~sdaPrev_r & sdaIn;
endmodule
`default_nettype wire

// ---- hw/i2c_sensor_command_decoder.sv ----
// serial command front end of the sensor core: i2c slave, decode, crc
// assumes bus lines synchronous to clk and a core that acts on cmdStrobe
`timescale 1ns/1ps
`default_nettype none
`include "cmd_decoder_map.svh"
module i2c_sensor_command_decoder (
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          sclIn,
  input  wire logic          sdaIn,
  input  wire logic          altAddrStrap,
  input  wire cmd_pkg::busy_t busy,
  input  wire logic [63:0]   idWords,
  input  wire logic [15:0]   rdWord,
  input  wire cmd_pkg::adc_t adc,
  output logic               sdaOut,
  output logic               sdaOe,
  output logic               statusOutPin,
  output logic               cmdStrobe,
  output logic               crcError,
  output cmd_pkg::cmd_t      cmd
);
  cmd_pkg::link_state_t st_r;
  cmd_pkg::phase_t      phase_r, phase_nxt;
  cmd_pkg::cmd_kind_t   kind_r, kind_nxt, dKind;
  cmd_pkg::cmd_t        cmdVal, cmd_r;
  logic [3:0]  bitCnt_r;
  logic [7:0]  shift_r, txByte_r, txByte_nxt;
  logic [7:0]  crcAcc_r, crcAcc_nxt, crcByte, crcNew;
  logic [2:0]  sel_r, sel_nxt;
  logic [7:0]  addr_r, addr_nxt;
  logic [15:0] data_r, data_nxt;
  logic [71:0] txBuf_r, txBuf_nxt, adcBuf;
  logic [3:0]  txLeft_r, txLeft_nxt, adcCnt;
  logic [1:0]  pair_r, pair_nxt;
  logic        dCnt_r, dCnt_nxt, crcOn_r, crcOn_nxt, crcBad_r, crcBad_nxt;
  logic        needAddr_r, needAddr_nxt, wrData_r, wrData_nxt, dAddr, dData;
  logic        rdArmed_r, rdArmed_nxt, txGo_r, mAck_r;
  logic        ackIt, toTx, toSkip, finish, refused, issue, crcFail;
  logic        sclRise, sclFall, startSeen, stopSeen, byteEnd, loadByte;
  logic        altSel_r, capDone_r, sdaOe_r, sdaOut_r;
  logic        statusOut_r, cmdStrobe_r, crcErr_r;
  logic [6:0]  devAddr;

  i2c_bus_watch watch (
    .clk       (clk),
    .rst       (rst),
    .sclIn     (sclIn),
    .sdaIn     (sdaIn),
    .sclRise   (sclRise),
    .sclFall   (sclFall),
    .startSeen (startSeen),
    .stopSeen  (stopSeen)
  );

  // one shared crc step, receive and transmit never overlap
  assign crcByte = (st_r == cmd_pkg::ST_RX) ? shift_r : txBuf_r[71:64];
  crc8_step crc (
    .crcIn  (crcAcc_r),
    .dataIn (crcByte),
    .crcOut (crcNew)
  );

  // strap caught once, the cycle after reset release
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      altSel_r  <= 1'b0;
      capDone_r <= 1'b0;
    end else if (!capDone_r) begin
      altSel_r  <= altAddrStrap;
      capDone_r <= 1'b1;
    end
  end
  assign devAddr = altSel_r ? `SLAVE_ADDR_ALT : `SLAVE_ADDR_STD;

  // full-opcode commands and their byte counts
  always_comb begin
    dKind = cmd_pkg::CK_NONE;
    dAddr = 1'b0;
    dData = 1'b0;
    case (shift_r[7:1])
      `OP_READ_ID:    dKind = cmd_pkg::CK_READ_ID;
      `OP_RESET:      dKind = cmd_pkg::CK_RESET;
      `OP_REFRESH:    dKind = cmd_pkg::CK_REFRESH;
      `OP_WR_OPMODE: begin
        dKind = cmd_pkg::CK_WR_OPMODE;
        dData = 1'b1;
      end
      `OP_RD_OPMODE:  dKind = cmd_pkg::CK_RD_OPMODE;
      `OP_AUTO_START: dKind = cmd_pkg::CK_AUTO_START;
      `OP_AUTO_STOP:  dKind = cmd_pkg::CK_AUTO_STOP;
      `OP_CONVERT:    dKind = cmd_pkg::CK_CONVERT;
      // address byte, writes add a data pair
      `OP_WR_NVM: begin
        dKind = cmd_pkg::CK_WR_NVM;
        dAddr = 1'b1;
        dData = 1'b1;
      end
      `OP_ERASE_NVM: begin
        dKind = cmd_pkg::CK_ERASE_NVM;
        dAddr = 1'b1;
      end
      `OP_RD_NVM: begin
        dKind = cmd_pkg::CK_RD_NVM;
        dAddr = 1'b1;
      end
      `OP_WR_REG: begin
        dKind = cmd_pkg::CK_WR_REG;
        dAddr = 1'b1;
        dData = 1'b1;
      end
      `OP_RD_REG: begin
        dKind = cmd_pkg::CK_RD_REG;
        dAddr = 1'b1;
      end
      default: begin
        if (shift_r[7:3] == `OP_WR_CFG) begin
          dKind = cmd_pkg::CK_WR_CFG;
          dData = 1'b1;
        end else if (shift_r[7:3] == `OP_RD_CFG) begin
          dKind = cmd_pkg::CK_RD_CFG;
        end else if (shift_r[7:3] == `OP_WR_MASK) begin
          dKind = cmd_pkg::CK_WR_MASK;
          dData = 1'b1;
        end else if (shift_r[7:3] == `OP_RD_MASK) begin
          dKind = cmd_pkg::CK_RD_MASK;
        end else if (shift_r[7:3] == `OP_WR_INT) begin
          dKind = cmd_pkg::CK_WR_INT;
          dData = 1'b1;
        end else if (shift_r[7:3] == `OP_RD_INT) begin
          dKind = cmd_pkg::CK_RD_INT;
        // three-bit select and channel select commands
        end else if (shift_r[7:4] == `OP_WR_LIM) begin
          dKind = cmd_pkg::CK_WR_LIM;
          dData = 1'b1;
        end else if (shift_r[7:4] == `OP_RD_LIM) begin
          dKind = cmd_pkg::CK_RD_LIM;
        end else if (shift_r[7:4] == `OP_RD_ADC) begin
          dKind = cmd_pkg::CK_RD_ADC;
        end
      end
    endcase
  end

  // selected results packed pressure first, then T1, then T2
  always_comb begin
    adcBuf = 72'h0;
    adcCnt = 4'h0;
    if (sel_r[2]) begin
      adcBuf = {adc.temp2, 48'h0};
      adcCnt = 4'h3;
    end
    if (sel_r[1]) begin
      adcBuf = {adc.temp1, adcBuf[71:24]};
      adcCnt = adcCnt + 4'h3;
    end
    if (sel_r[0]) begin
      adcBuf = {adc.pres, adcBuf[71:24]};
      adcCnt = adcCnt + 4'h3;
    end
  end

  assign byteEnd  = (st_r == cmd_pkg::ST_RX) && sclFall && (bitCnt_r == 4'h8);
  assign loadByte = sclFall && (((st_r == cmd_pkg::ST_ACK) && txGo_r) ||
                                ((st_r == cmd_pkg::ST_TXACK) && mAck_r));

  // byte-level collection of address, command, crc and data
  always_comb begin
    phase_nxt    = phase_r;
    kind_nxt     = kind_r;
    sel_nxt      = sel_r;
    crcOn_nxt    = crcOn_r;
    crcBad_nxt   = crcBad_r;
    addr_nxt     = addr_r;
    data_nxt     = data_r;
    dCnt_nxt     = dCnt_r;
    crcAcc_nxt   = crcAcc_r;
    rdArmed_nxt  = rdArmed_r;
    needAddr_nxt = needAddr_r;
    wrData_nxt   = wrData_r;
    txBuf_nxt    = txBuf_r;
    txLeft_nxt   = txLeft_r;
    pair_nxt     = pair_r;
    txByte_nxt   = txByte_r;
    ackIt        = 1'b0;
    toTx         = 1'b0;
    toSkip       = 1'b0;
    finish       = 1'b0;
    if (startSeen) begin
      phase_nxt = cmd_pkg::PH_ADDR;
    end else if (byteEnd) begin
      ackIt = 1'b1;
      case (phase_r)
        cmd_pkg::PH_ADDR: begin
          crcAcc_nxt = `CRC_INIT;
          pair_nxt   = 2'h0;
          if (shift_r[7:1] != devAddr) begin
            ackIt  = 1'b0;
            toSkip = 1'b1;
          end else if (shift_r[0]) begin
            // read address loads the answer of the armed command
            toTx      = 1'b1;
            phase_nxt = cmd_pkg::PH_DONE;
            txBuf_nxt = {rdWord, 56'h0};
            txLeft_nxt = rdArmed_r ? `LEN_WORD : 4'h0;
            if (rdArmed_r && kind_r == cmd_pkg::CK_READ_ID) begin
              txBuf_nxt  = {idWords, 8'h0};
              txLeft_nxt = `LEN_READ_ID;
            end else if (rdArmed_r && kind_r == cmd_pkg::CK_RD_ADC) begin
              txBuf_nxt  = adcBuf;
              txLeft_nxt = adcCnt;
            end
          end else begin
            phase_nxt = cmd_pkg::PH_CMD;
          end
        end
        cmd_pkg::PH_CMD: begin
          // bits 7:1 opcode, bit 0 crc enable
          kind_nxt     = dKind;
          sel_nxt      = shift_r[3:1];
          crcOn_nxt    = shift_r[0];
          crcAcc_nxt   = crcNew;
          crcBad_nxt   = 1'b0;
          needAddr_nxt = dAddr;
          wrData_nxt   = dData;
          dCnt_nxt     = 1'b0;
          rdArmed_nxt  = 1'b0;
          // empty channel select is not acknowledged
          if (dKind == cmd_pkg::CK_RD_ADC && shift_r[3:1] == 3'h0) begin
            ackIt     = 1'b0;
            toSkip    = 1'b1;
            kind_nxt  = cmd_pkg::CK_NONE;
            phase_nxt = cmd_pkg::PH_DONE;
          end else if (shift_r[0]) begin
            phase_nxt = cmd_pkg::PH_CCRC;
          end else if (dAddr) begin
            phase_nxt = cmd_pkg::PH_RADDR;
          end else if (dData) begin
            phase_nxt = cmd_pkg::PH_DATA;
          end else begin
            finish = 1'b1;
          end
        end
        cmd_pkg::PH_CCRC: begin
          // command integrity checked on its own
          crcBad_nxt = (shift_r != crcAcc_r);
          crcAcc_nxt = `CRC_INIT;
          if (needAddr_r) begin
            phase_nxt = cmd_pkg::PH_RADDR;
          end else if (wrData_r) begin
            phase_nxt = cmd_pkg::PH_DATA;
          end else begin
            finish = 1'b1;
          end
        end
        cmd_pkg::PH_RADDR: begin
          addr_nxt = shift_r;
          if (wrData_r) begin
            phase_nxt = cmd_pkg::PH_DATA;
          end else begin
            finish = 1'b1;
          end
        end
        cmd_pkg::PH_DATA: begin
          // data pair msb first, crc accumulated per pair
          data_nxt   = {data_r[7:0], shift_r};
          crcAcc_nxt = crcNew;
          dCnt_nxt   = ~dCnt_r;
          if (dCnt_r) begin
            if (crcOn_r) begin
              phase_nxt = cmd_pkg::PH_DCRC;
            end else begin
              finish = 1'b1;
            end
          end
        end
        cmd_pkg::PH_DCRC: begin
          crcBad_nxt = crcBad_r | (shift_r != crcAcc_r);
          crcAcc_nxt = `CRC_INIT;
          finish     = 1'b1;
        end
        default: ;
      endcase
    end
    if (finish) begin
      phase_nxt = cmd_pkg::PH_DONE;
    end
    cmdVal = '{kind: kind_nxt, sel: sel_nxt, addr: addr_nxt, data: data_nxt};
    // config write refused while converting or automatic
    // register writes outside page 4 refused
    refused = (kind_nxt == cmd_pkg::CK_WR_CFG && (busy.convRunning || busy.autoMode)) ||
              (kind_nxt == cmd_pkg::CK_CONVERT && busy.convRunning) ||
              (kind_nxt == cmd_pkg::CK_WR_REG && addr_nxt[7:5] != `USER_PAGE_BITS);
    // bad crc blocks execution and flags an error
    issue   = finish && !crcBad_nxt && kind_nxt != cmd_pkg::CK_NONE && !refused;
    crcFail = finish && crcBad_nxt;
    if (issue && !wrData_nxt) begin
      rdArmed_nxt = 1'b1;
    end
    // burst register write continues at the next address
    if (finish && kind_nxt == cmd_pkg::CK_WR_REG) begin
      phase_nxt  = cmd_pkg::PH_DATA;
      addr_nxt   = addr_nxt + 8'h01;
      crcBad_nxt = 1'b0;
    end
    // transmit byte choice, crc after each pair and after an odd tail
    if (loadByte) begin
      if (crcOn_r && (pair_r == 2'h2 || (txLeft_r == 4'h0 && pair_r != 2'h0))) begin
        txByte_nxt = crcAcc_r;
        pair_nxt   = 2'h0;
        crcAcc_nxt = `CRC_INIT;
      end else if (txLeft_r != 4'h0) begin
        txByte_nxt = txBuf_r[71:64];
        txBuf_nxt  = {txBuf_r[63:0], 8'h0};
        txLeft_nxt = txLeft_r - 4'h1;
        pair_nxt   = pair_r + 2'h1;
        crcAcc_nxt = crcNew;
      end else begin
        txByte_nxt = 8'hff;
      end
    end
  end

  // collection registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phase_r    <= cmd_pkg::PH_ADDR;
      kind_r     <= cmd_pkg::CK_NONE;
      sel_r      <= 3'h0;
      crcOn_r    <= 1'b0;
      crcBad_r   <= 1'b0;
      addr_r     <= 8'h00;
      data_r     <= 16'h0000;
      dCnt_r     <= 1'b0;
      crcAcc_r   <= `CRC_INIT;
      rdArmed_r  <= 1'b0;
      needAddr_r <= 1'b0;
      wrData_r   <= 1'b0;
      txBuf_r    <= 72'h0;
      txLeft_r   <= 4'h0;
      pair_r     <= 2'h0;
      txByte_r   <= 8'hff;
    end else begin
      phase_r    <= phase_nxt;
      kind_r     <= kind_nxt;
      sel_r      <= sel_nxt;
      crcOn_r    <= crcOn_nxt;
      crcBad_r   <= crcBad_nxt;
      addr_r     <= addr_nxt;
      data_r     <= data_nxt;
      dCnt_r     <= dCnt_nxt;
      crcAcc_r   <= crcAcc_nxt;
      rdArmed_r  <= rdArmed_nxt;
      needAddr_r <= needAddr_nxt;
      wrData_r   <= wrData_nxt;
      txBuf_r    <= txBuf_nxt;
      txLeft_r   <= txLeft_nxt;
      pair_r     <= pair_nxt;
      txByte_r   <= txByte_nxt;
    end
  end

  // bit-level slave, only ever pulls sda low, never drives scl
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r     <= cmd_pkg::ST_IDLE;
      bitCnt_r <= 4'h0;
      shift_r  <= 8'h00;
      sdaOe_r  <= 1'b0;
      txGo_r   <= 1'b0;
      mAck_r   <= 1'b0;
    end else if (startSeen) begin
      st_r     <= cmd_pkg::ST_RX;
      bitCnt_r <= 4'h0;
      sdaOe_r  <= 1'b0;
    end else if (stopSeen) begin
      st_r    <= cmd_pkg::ST_IDLE;
      sdaOe_r <= 1'b0;
    end else begin
      case (st_r)
        cmd_pkg::ST_RX: begin
          if (sclRise && bitCnt_r != 4'h8) begin
            shift_r  <= {shift_r[6:0], sdaIn};
            bitCnt_r <= bitCnt_r + 4'h1;
          end
          if (byteEnd) begin
            txGo_r  <= toTx;
            sdaOe_r <= ackIt;
            st_r    <= toSkip ? cmd_pkg::ST_SKIP : cmd_pkg::ST_ACK;
          end
        end
        cmd_pkg::ST_ACK: begin
          if (sclFall) begin
            bitCnt_r <= txGo_r ? 4'h1 : 4'h0;
            sdaOe_r  <= txGo_r ? ~txByte_nxt[7] : 1'b0;
            st_r     <= txGo_r ? cmd_pkg::ST_TX : cmd_pkg::ST_RX;
          end
        end
        cmd_pkg::ST_TX: begin
          if (sclFall && bitCnt_r == 4'h8) begin
            sdaOe_r <= 1'b0;
            st_r    <= cmd_pkg::ST_TXACK;
          end else if (sclFall) begin
            sdaOe_r  <= ~txByte_r[3'h7 - bitCnt_r[2:0]];
            bitCnt_r <= bitCnt_r + 4'h1;
          end
        end
        cmd_pkg::ST_TXACK: begin
          if (sclRise) begin
            mAck_r <= ~sdaIn;
          end
          if (sclFall) begin
            bitCnt_r <= 4'h1;
            sdaOe_r  <= mAck_r ? ~txByte_nxt[7] : 1'b0;
            st_r     <= mAck_r ? cmd_pkg::ST_TX : cmd_pkg::ST_SKIP;
          end
        end
        default: ;
      endcase
    end
  end

  // command hand-off to the core and error pulse
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cmd_r       <= '0;
      cmdStrobe_r <= 1'b0;
      crcErr_r    <= 1'b0;
      sdaOut_r    <= 1'b0;
    end else begin
      if (issue) begin
        cmd_r <= cmdVal;
      end
      cmdStrobe_r <= issue;
      crcErr_r    <= crcFail;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      statusOut_r <= 1'b0;
    end else begin
      statusOut_r <= ~(issue | (|busy));
    end
  end

  assign sdaOut       = sdaOut_r;
  assign sdaOe        = sdaOe_r;
  assign statusOutPin = statusOut_r;
  assign cmdStrobe    = cmdStrobe_r;
  assign crcError     = crcErr_r;
  assign cmd          = cmd_r;
endmodule
`default_nettype wire

// ---- sim/cmd_decoder_asserts.sv ----
// assertions on the command front end ports
// assumes binding to the decoder top, single clock domain
`timescale 1ns/1ps
`default_nettype none
module cmd_decoder_asserts (
  input wire logic           clk,
  input wire logic           rst,
  input wire cmd_pkg::busy_t busy,
  input wire logic           statusOutPin,
  input wire logic           cmdStrobe,
  input wire logic           crcError,
  input wire cmd_pkg::cmd_t  cmd
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // status level follows accept and busy
  status_level_a: assert property (
    !$past(rst) |-> statusOutPin == !(cmdStrobe || $past(|busy)))
    else $error("status level wrong");
  pulse_low_a: assert property (cmdStrobe |-> !statusOutPin)
    else $error("status not low on accept");
  one_pulse_a: assert property (cmdStrobe |=> !cmdStrobe)
    else $error("accept longer than one cycle");
  cmd_hold_a: assert property (!cmdStrobe |-> $stable(cmd))
    else $error("command changed without strobe");
  conv_refuse_a: assert property (cmdStrobe && $past(busy.convRunning) |->
    cmd.kind != cmd_pkg::CK_CONVERT && cmd.kind != cmd_pkg::CK_WR_CFG)
    else $error("command taken during conversion");
  auto_refuse_a: assert property (
    cmdStrobe && $past(busy.autoMode) |-> cmd.kind != cmd_pkg::CK_WR_CFG)
    else $error("config write taken in auto mode");
  page_four_a: assert property (
    cmdStrobe && cmd.kind == cmd_pkg::CK_WR_REG |-> cmd.addr[7:5] == 3'h3)
    else $error("register write outside page");
  adc_sel_a: assert property (
    cmdStrobe && cmd.kind == cmd_pkg::CK_RD_ADC |-> cmd.sel != 3'h0)
    else $error("adc read with no channel");
  crc_block_a: assert property (crcError |-> !cmdStrobe)
    else $error("command run despite crc error");
  // main scenarios reached
  cover property (cmdStrobe);
  cover property (crcError);
  cover property (busy.convRunning ##1 !statusOutPin);
endmodule
bind i2c_sensor_command_decoder cmd_decoder_asserts chk_u (
  .clk, .rst, .busy, .statusOutPin, .cmdStrobe, .crcError, .cmd);
`default_nettype wire

// ---- sim/i2c_master_model.sv ----
// bus master model driving clock and data toward the decoder
// assumes an open-drain data wire with pull-up resolved by the bench
`timescale 1ns/1ps
`default_nettype none
module i2c_master_model (
  input  wire logic clk,
  input  wire logic sdaW,
  output var logic  scl,
  output var logic  sda
);
  // bus idles released
  initial begin
    scl = 1;
    sda = 1;
  end
  // one third of a written bit, half a read bit, of bus time
  task automatic w;
    repeat (4) @(posedge clk);
    #1;
  endtask
  task automatic start;
    w;
    sda = 0;
    w;
    scl = 0;
    w;
  endtask
  task automatic stop;
    sda = 0;
    w;
    scl = 1;
    w;
    sda = 1;
    w;
  endtask
  task automatic wrByte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda = b[i];
      w;
      scl = 1;
      w;
      scl = 0;
      w;
    end
    sda = 1;
    w;
    scl = 1;
    w;
    ack = !sdaW;
    scl = 0;
    w;
  endtask
  // eight bits from the slave msb first, then ack or nack
  task automatic rdByte(input logic more, output logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      w;
      scl = 1;
      w;
      b[i] = sdaW;
      scl = 0;
    end
    sda = !more;
    w;
    scl = 1;
    w;
    scl = 0;
    sda = 1;
    w;
  endtask
endmodule
`default_nettype wire

// ---- sim/i2c_sensor_command_decoder_tb_top.sv ----
// self-checking bench for the command front end
// assumes the master model and bound checker
`timescale 1ns/1ps
`default_nettype none
module i2c_sensor_command_decoder_tb_top;
  logic           clk, rst, scl, sdaM, sdaOut, sdaOe, statusOutPin, cmdStrobe, crcError;
  cmd_pkg::busy_t busy;
  cmd_pkg::cmd_t  cmd, lastCmd;
  logic [1:0]     ak;
  logic           altStrap;
  // arbitrary id pattern answered by the read id command
  localparam logic [63:0] ID_VAL = 64'h0123_4567_89ab_cdef;
  int             bad_count, tests_run, nStb, nErr, nLow;
  wire            sdaW = sdaM & ~sdaOe;
  i2c_master_model mdl_u (.clk(clk), .sdaW(sdaW), .scl(scl), .sda(sdaM));
  i2c_sensor_command_decoder dut_u (.clk(clk), .rst(rst), .sclIn(scl), .sdaIn(sdaW),
    .altAddrStrap(altStrap), .busy(busy), .idWords(ID_VAL), .rdWord(16'h0), .adc(72'h0),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .statusOutPin(statusOutPin), .cmdStrobe(cmdStrobe),
    .crcError(crcError), .cmd(cmd));
  // clock of 10 ns
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  // strobe, error and status low counters
  always @(posedge clk) begin
    if (cmdStrobe === 1'b1) begin
      nStb++;
      lastCmd = cmd;
    end
    if (crcError === 1'b1) nErr++;
    if (statusOutPin === 1'b0) nLow++;
  end
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic logic [7:0] crc8(logic [7:0] b);
    logic [7:0] c;
    c = b;
    for (int i = 0; i < 8; i++) c = c[7] ? {c[6:0], 1'b0} ^ 8'h31 : {c[6:0], 1'b0};
    return c;
  endfunction
  // one write transfer; ak holds address and first byte acks
  task automatic xfer(logic [7:0] a, logic [7:0] b[$]);
    logic k;
    nStb = 0;
    nErr = 0;
    nLow = 0;
    mdl_u.start();
    mdl_u.wrByte(a, ak[1]);
    foreach (b[i]) begin
      mdl_u.wrByte(b[i], k);
      if (i == 0) ak[0] = k;
    end
    mdl_u.stop();
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic t_fixed;
    logic [7:0] op[6] = '{8'h08, 8'h10, 8'h12, 8'h18, 8'h1a, 8'h4e};
    cmd_pkg::cmd_kind_t k[6] = '{cmd_pkg::CK_READ_ID, cmd_pkg::CK_RESET,
      cmd_pkg::CK_REFRESH, cmd_pkg::CK_AUTO_START, cmd_pkg::CK_AUTO_STOP, cmd_pkg::CK_CONVERT};
    for (int i = 0; i < 6; i++) begin
      xfer(8'he8, '{op[i]});
      check("strobes", nStb, 1);
      check("low cycles", nLow, 1);
      check("kind", lastCmd.kind, k[i]);
    end
    $display("done fixed");
  endtask
  task automatic t_crc;
    xfer(8'he8, '{8'h11, crc8(8'h11)});
    check("crc ok strobe", nStb, 1);
    xfer(8'he8, '{8'h11, crc8(8'h11) ^ 8'h01});
    check("crc bad strobe", nStb, 0);
    check("crc bad flag", nErr, 1);
    check("crc bad acks", ak, 2'b11);
    $display("done crc");
  endtask
  task automatic t_refuse;
    busy.convRunning = 1;
    xfer(8'he8, '{8'h20, 8'h12, 8'h34});
    check("cfg in conv", nStb, 0);
    xfer(8'he8, '{8'h4e});
    check("conv in conv", nStb, 0);
    check("status busy", statusOutPin, 0);
    busy = '0;
    busy.autoMode = 1;
    xfer(8'he8, '{8'h20, 8'h12, 8'h34});
    check("cfg in auto", nStb, 0);
    busy = '0;
    xfer(8'he8, '{8'h22, 8'h12, 8'h34});
    check("cfg ok", {nStb[2:0], lastCmd.kind, lastCmd.sel, lastCmd.data},
      {3'h1, cmd_pkg::CK_WR_CFG, 3'h1, 16'h1234});
    $display("done refuse");
  endtask
  task automatic t_invalid;
    xfer(8'he8, '{8'h50});
    check("adc no sel acks", {ak, nStb[1:0]}, 4'b1000);
    xfer(8'he8, '{8'h00, 8'h00});
    check("unknown", {ak, nStb[1:0], nLow[1:0]}, 6'b110000);
    xfer(8'h90, '{8'h10});
    check("other addr", {ak[1], nStb[1:0]}, 3'b000);
    $display("done invalid");
  endtask
  task automatic t_wreg;
    xfer(8'he8, '{8'he0, 8'h61, 8'hbe, 8'hef});
    check("reg write", {nStb[2:0], lastCmd.kind, lastCmd.addr, lastCmd.data},
      {3'h1, cmd_pkg::CK_WR_REG, 8'h61, 16'hbeef});
    xfer(8'he8, '{8'he0, 8'h20, 8'h12, 8'h34});
    check("reg off page", nStb, 0);
    $display("done wreg");
  endtask
  // read id answered byte by byte, master nacks the last
  task automatic t_read;
    logic [7:0] d;
    logic       k;
    xfer(8'he8, '{8'h08});
    mdl_u.start();
    mdl_u.wrByte(8'he9, k);
    check("read addr ack", k, 1);
    for (int i = 0; i < 8; i++) begin
      mdl_u.rdByte(i < 7, d);
      check("id byte", d, ID_VAL[63 - 8 * i -: 8]);
    end
    mdl_u.stop();
    repeat (3) @(posedge clk);
    #1;
    $display("done read");
  endtask
  // strap picks the alternative address after a fresh reset
  task automatic t_alt;
    altStrap = 1;
    rst = 1;
    repeat (2) @(posedge clk);
    #1;
    rst = 0;
    repeat (3) @(posedge clk);
    #1;
    check("alt idle", statusOutPin, 1);
    xfer(8'he8, '{8'h10});
    check("std addr off", {ak[1], nStb[1:0]}, 3'b000);
    xfer(8'h44, '{8'h10});
    check("alt addr", {ak[1], nStb[1:0]}, 3'b101);
    $display("done alt");
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // watchdog at 20000 cycles, about three times the expected run
  initial begin
    #200000;
    bad_count++;
    end_of_test();
  end
  // main sequence
  initial begin
    rst = 1;
    busy = '0;
    altStrap = 0;
    repeat (5) @(posedge clk);
    #1;
    rst = 0;
    repeat (3) @(posedge clk);
    #1;
    check("idle status", {statusOutPin, sdaOut, sdaOe}, 3'b100);
    t_fixed();
    t_crc();
    t_refuse();
    t_invalid();
    t_wreg();
    t_read();
    t_alt();
    end_of_test();
  end
endmodule
`default_nettype wire
